// file: rtl/flash_ctrl_abort_status.sv
// Purpose: Abort status capture and embedded flash controller.
// Assumes: Masters present one access at a time on the memory port.
// Notes:   Flash plane and latch are arrays without reset.
`timescale 1ns/1ps
module flash_ctrl_abort_status
    import flash_ctrl_pkg::*;
(
    // Clock and reset
    input  wire logic        clock,
    input  wire logic        rst_n,
    input  wire logic        ce,
    // AXI4-Lite register bus
    input  wire logic [7:0]  awaddr,
    input  wire logic        awvalid,
    output logic             awready,
    input  wire logic [31:0] wdata,
    input  wire logic [3:0]  wstrb,
    input  wire logic        wvalid,
    output logic             wready,
    output logic [1:0]       bresp,
    output logic             bvalid,
    input  wire logic        bready,
    input  wire logic [7:0]  araddr,
    input  wire logic        arvalid,
    output logic             arready,
    output logic [31:0]      rdata,
    output logic [1:0]       rresp,
    output logic             rvalid,
    input  wire logic        rready,
    // Memory access port
    input  wire logic        memReq,
    input  wire logic [31:0] memAddr,
    input  wire logic [1:0]  memSize,
    input  wire logic [1:0]  memType,
    input  wire logic [2:0]  memMaster,
    input  wire logic [31:0] memWdata,
    output logic             memAck,
    output logic             memAbort,
    output logic [31:0]      memRdata,
    // Interrupt
    output logic             irq
);
    typedef enum logic [1:0] {ACC_IDLE = 2'b01, ACC_WAIT = 2'b10} acc_t;
    typedef enum logic [1:0] {CMD_IDLE = 2'b01, CMD_RUN = 2'b10} cmd_t;

    typedef struct packed {
        logic        bvalid;
        logic [1:0]  bresp;
        logic        rvalid;
        logic [1:0]  rresp;
        logic [31:0] rdata;
        logic        undef;
        logic        misal;
        logic [1:0]  size;
        logic [1:0]  typ;
        logic [2:0]  src;
        logic [2:0]  saved;
        logic        unread;
        logic [31:0] abtAddr;
        logic [1:0]  flash_wait_states;
        logic [7:0]  microsecond_cycle_count;
        logic        doneIe;
        logic        lockIe;
        logic        done;
        logic        progErr;
        logic        lockErr;
        logic        doExec;
        cmd_t        cmd;
        logic [7:0]  cmdCnt;
        logic [7:0]  code;
        logic [3:0]  page;
        logic [3:0]  locks;
        logic [2:0]  gp;
        logic        sec;
        acc_t        acc;
        logic [1:0]  waitCnt;
        logic        abortResp;
        logic [31:0] memData;
        logic [29:0] lastWord;
        logic        lastFetch;
        logic        posOdd;
    } state_t;

    state_t s_q, s_d;
    logic [31:0] flashMem [PAGES*PAGE_WORDS];
    logic [31:0] latchMem [PAGE_WORDS];

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic [1:0] waitsFor(input logic [1:0] ws, input logic isWrite,
                                            input logic isSeq, input logic odd);
        if (isWrite) begin
            waitsFor = (ws == 2'h3) ? 2'h3 : 2'(ws + 2'h1);
        end else if (!isSeq) begin
            waitsFor = ws;
        end else if (ws == 2'h1) begin
            waitsFor = 2'h0;
        end else begin
            waitsFor = odd ? ws : 2'h0;
        end
    endfunction

    function automatic logic [3:0] regionMask(input logic [3:0] pg);
        regionMask = 4'h1 << pg[3:2];
    endfunction

    function automatic logic validCode(input logic [7:0] c);
        unique case (c)
            WRITE_PAGE_CMD, SET_LOCK_CMD, WRITE_PAGE_LOCK_CMD, CLEAR_LOCK_CMD,
            ERASE_ALL_CMD, SET_GP_BIT_CMD, CLEAR_GP_BIT_CMD,
            SET_SECURITY_CMD: validCode = 1'b1;
            default:          validCode = 1'b0;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // Decode of the present access and bus handshakes
    // ----------------------------------------------------------------
    logic accStart, isUndef, isMisal, isAbort, isFlash, isSeq, wrTake, rdTake;
    logic cmdWrite, abortEvt;
    logic [3:0] cmdPage;
    logic [7:0] cmdCode;

    assign accStart = ce && memReq && (s_q.acc == ACC_IDLE);
    assign isUndef  = (memAddr[31:22] != 10'h000);
    assign isMisal  = (memType != TYPE_FETCH) &&
                      (((memSize == SIZE_WORD) && (memAddr[1:0] != 2'h0)) ||
                       ((memSize == SIZE_HALF) && memAddr[0]));
    assign isAbort  = isUndef || isMisal;
    assign abortEvt = accStart && isAbort;
    assign isFlash  = (memAddr[21] == 1'b0);
    // Only fetches continue a sequence; data reads bypass the buffers
    assign isSeq    = (memType == TYPE_FETCH) && s_q.lastFetch &&
                      (memAddr[31:2] == 30'(s_q.lastWord + 30'h1));
    assign awready  = ce && !s_q.bvalid && awvalid && wvalid;
    assign wready   = awready;
    assign wrTake   = awready;
    assign arready  = ce && !s_q.rvalid;
    assign rdTake   = arready && arvalid;
    assign cmdWrite = wrTake && (awaddr == OFS_FLASH_CMD) && (s_q.cmd == CMD_IDLE);
    assign cmdCode  = wdata[POS_PAGE-1:0];
    assign cmdPage  = wdata[POS_PAGE+3:POS_PAGE];

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        logic [2:0] oldSaved;
        oldSaved = s_q.saved;
        s_d = s_q;
        s_d.doExec = 1'b0;

        if (s_q.bvalid && bready) begin
            s_d.bvalid = 1'b0;
        end
        if (s_q.rvalid && rready) begin
            s_d.rvalid = 1'b0;
        end

        if (rdTake) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = RESP_OKAY;
            s_d.rdata  = 32'h0;
            unique case (araddr)
                OFS_ABORT_STATUS: begin
                    s_d.rdata[POS_UNDEF]              = s_q.undef;
                    s_d.rdata[POS_MISAL]              = s_q.misal;
                    s_d.rdata[POS_SIZE+1:POS_SIZE]    = s_q.size;
                    s_d.rdata[POS_TYPE+1:POS_TYPE]    = s_q.typ;
                    s_d.rdata[POS_SRC+2:POS_SRC]      = s_q.src;
                    s_d.rdata[POS_SAVED+2:POS_SAVED]  = s_q.saved;
                    oldSaved   = 3'h0;
                    s_d.saved  = 3'h0;
                    s_d.unread = 1'b0;
                end
                OFS_ABORT_ADDRESS: s_d.rdata = s_q.abtAddr;
                OFS_FLASH_MODE: begin
                    s_d.rdata[0]                      = s_q.doneIe;
                    s_d.rdata[POS_LOCK_ERROR_FLAG]              = s_q.lockIe;
                    s_d.rdata[POS_FWS+1:POS_FWS]      = s_q.flash_wait_states;
                    s_d.rdata[POS_MICROSECOND_CYCLE_COUNT+7:POS_MICROSECOND_CYCLE_COUNT]    = s_q.microsecond_cycle_count;
                end
                OFS_FLASH_STATUS: begin
                    s_d.rdata[POS_DONE]               = s_q.done;
                    s_d.rdata[POS_LOCK_ERROR_FLAG]              = s_q.lockErr;
                    s_d.rdata[POS_PROGRAM_ERROR_FLAG]              = s_q.progErr;
                    s_d.rdata[POS_SEC]                = s_q.sec;
                    s_d.rdata[POS_GP+2:POS_GP]        = s_q.gp;
                    s_d.rdata[POS_LOCKS+3:POS_LOCKS]  = s_q.locks;
                    s_d.progErr = 1'b0;
                    s_d.lockErr = 1'b0;
                end
                OFS_FLASH_CMD:     s_d.rdata = 32'h0;
                default:           s_d.rresp = RESP_SLVERR;
            endcase
        end

        if (wrTake) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = RESP_OKAY;
            unique case (awaddr)
                OFS_FLASH_MODE: begin
                    if (wstrb[0]) begin
                        s_d.doneIe = wdata[0];
                        s_d.lockIe = wdata[POS_LOCK_ERROR_FLAG];
                    end
                    if (wstrb[1]) begin
                        s_d.flash_wait_states = wdata[POS_FWS+1:POS_FWS];
                    end
                    if (wstrb[2]) begin
                        s_d.microsecond_cycle_count = wdata[POS_MICROSECOND_CYCLE_COUNT+7:POS_MICROSECOND_CYCLE_COUNT];
                    end
                end
                OFS_ABORT_STATUS, OFS_ABORT_ADDRESS, OFS_FLASH_CMD,
                OFS_FLASH_STATUS: s_d.bresp = RESP_OKAY;
                default:          s_d.bresp = RESP_SLVERR;
            endcase
        end

        // Command engine; a write while busy is dropped
        unique case (s_q.cmd)
            CMD_IDLE: begin
                if (cmdWrite) begin
                    s_d.done   = 1'b0;
                    s_d.cmd    = CMD_RUN;
                    s_d.cmdCnt = s_q.microsecond_cycle_count;
                    s_d.code   = cmdCode;
                    s_d.page   = cmdPage;
                    if (wdata[31:POS_KEY] != CMD_KEY || !validCode(cmdCode)) begin
                        s_d.progErr = 1'b1;
                        s_d.cmdCnt  = 8'h00;
                        s_d.code    = 8'h00;
                    end else if (((cmdCode == WRITE_PAGE_CMD) ||
                                  (cmdCode == WRITE_PAGE_LOCK_CMD)) &&
                                 ((s_q.locks & regionMask(cmdPage)) != 4'h0)) begin
                        s_d.lockErr = 1'b1;
                        s_d.cmdCnt  = 8'h00;
                        s_d.code    = 8'h00;
                    end else if ((cmdCode == ERASE_ALL_CMD) && (s_q.locks != 4'h0)) begin
                        s_d.lockErr = 1'b1;
                        s_d.cmdCnt  = 8'h00;
                        s_d.code    = 8'h00;
                    end
                end
            end
            CMD_RUN: begin
                if (ce && s_q.cmdCnt != 8'h00) begin
                    s_d.cmdCnt = 8'(s_q.cmdCnt - 8'h01);
                end else if (ce) begin
                    s_d.cmd    = CMD_IDLE;
                    s_d.done   = 1'b1;
                    s_d.doExec = 1'b1;
                    unique case (s_q.code)
                        SET_LOCK_CMD, WRITE_PAGE_LOCK_CMD:
                            s_d.locks = s_q.locks | regionMask(s_q.page);
                        CLEAR_LOCK_CMD:
                            s_d.locks = s_q.locks & ~regionMask(s_q.page);
                        SET_GP_BIT_CMD, CLEAR_GP_BIT_CMD: begin
                            // Out-of-range general purpose bit numbers do nothing
                            if (s_q.page < 4'(GP_BITS)) begin
                                s_d.gp[s_q.page[1:0]] = (s_q.code == SET_GP_BIT_CMD);
                            end
                        end
                        SET_SECURITY_CMD: s_d.sec = 1'b1;
                        default:          s_d.sec = s_q.sec;
                    endcase
                end
            end
        endcase

        // Memory access sequencing
        unique case (s_q.acc)
            ACC_IDLE: begin
                if (accStart) begin
                    s_d.acc       = ACC_WAIT;
                    s_d.abortResp = isAbort;
                    s_d.waitCnt   = 2'h0;
                    s_d.memData   = 32'h0;
                    if (isAbort) begin
                        s_d.undef   = isUndef;
                        s_d.misal   = isMisal && !isUndef;
                        s_d.size    = memSize;
                        s_d.typ     = memType;
                        s_d.src     = memMaster;
                        s_d.abtAddr = memAddr;
                        // Previous source moves to saved unless already read
                        s_d.saved   = (oldSaved | (s_d.unread ? s_q.src : 3'h0))
                                      & ~memMaster;
                        s_d.unread  = 1'b1;
                    end else begin
                        s_d.waitCnt   = waitsFor(s_q.flash_wait_states, memType == TYPE_WRITE,
                                                 isSeq, !s_q.posOdd);
                        s_d.posOdd    = isSeq ? !s_q.posOdd : 1'b1;
                        s_d.lastFetch = (memType == TYPE_FETCH);
                        s_d.lastWord  = memAddr[31:2];
                        if (isFlash && memType != TYPE_WRITE) begin
                            // Flash aliases across its 2 MB area
                            s_d.memData = flashMem[memAddr[11:2]];
                        end
                    end
                end
            end
            ACC_WAIT: begin
                if (ce && s_q.waitCnt != 2'h0) begin
                    s_d.waitCnt = 2'(s_q.waitCnt - 2'h1);
                end else if (ce) begin
                    s_d.acc = ACC_IDLE;
                end
            end
        endcase

        if (!ce) begin
            s_d = s_q;
        end
    end

    always_ff @(posedge clock) begin
        if (!rst_n) begin
            s_q         <= '0;
            s_q.flash_wait_states     <= RST_FWS;
            s_q.microsecond_cycle_count    <= RST_MICROSECOND_CYCLE_COUNT;
            s_q.done    <= 1'b1;
            s_q.cmd     <= CMD_IDLE;
            s_q.acc     <= ACC_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    // ----------------------------------------------------------------
    // Flash plane and page latch
    // ----------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (ce && accStart && !isAbort && isFlash && memType == TYPE_WRITE) begin
            latchMem[memAddr[7:2]] <= memWdata;
        end
        if (ce && s_q.doExec && s_q.code == ERASE_ALL_CMD) begin
            for (int i = 0; i < PAGES*PAGE_WORDS; i++) begin
                flashMem[i] <= 32'hFFFFFFFF;
            end
        end else if (ce && s_q.doExec && (s_q.code == WRITE_PAGE_CMD ||
                                          s_q.code == WRITE_PAGE_LOCK_CMD)) begin
            for (int i = 0; i < PAGE_WORDS; i++) begin
                flashMem[{s_q.page, 6'(i)}] <= latchMem[i];
            end
        end
    end

    assign bvalid   = s_q.bvalid;
    assign bresp    = s_q.bresp;
    assign rvalid   = s_q.rvalid;
    assign rresp    = s_q.rresp;
    assign rdata    = s_q.rdata;
    assign memAck   = ce && (s_q.acc == ACC_WAIT) && (s_q.waitCnt == 2'h0);
    assign memAbort = memAck && s_q.abortResp;
    assign memRdata = s_q.memData;
    assign irq      = (s_q.done && s_q.doneIe) || (s_q.lockErr && s_q.lockIe);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rst_n);

    logic asrRead;
    assign asrRead = rdTake && (araddr == OFS_ABORT_STATUS);

    chk_undef_flag: assert property (abortEvt |=> s_q.undef == $past(isUndef))
        else $error("undefined address flag wrong");
    chk_misalign_flag: assert property (abortEvt && !isUndef |=> s_q.misal)
        else $error("misalign flag not set");
    chk_size_type: assert property (abortEvt |=> s_q.size == $past(memSize)
                                    && s_q.typ == $past(memType))
        else $error("abort size or type lost");
    chk_source_bits: assert property (abortEvt |=> s_q.src == $past(memMaster))
        else $error("abort source wrong");
    chk_saved_clear: assert property (asrRead && !abortEvt |=> s_q.saved == 3'h0)
        else $error("saved flags not cleared by read");
    chk_address_capture: assert property (abortEvt |=> s_q.abtAddr == $past(memAddr))
        else $error("abort address not captured");
    chk_ws0_single: assert property (accStart && !isAbort && s_q.flash_wait_states == 2'h0 &&
                                     memType != TYPE_WRITE |=> memAck)
        else $error("zero wait read not single cycle");
    chk_write_wait: assert property (accStart && !isAbort && s_q.flash_wait_states == 2'h0 &&
                                     memType == TYPE_WRITE |=> !memAck ##1 memAck)
        else $error("write wait count wrong");
    chk_done_clear: assert property (cmdWrite |=> !s_q.done)
        else $error("done not cleared by command");
    chk_irq_done: assert property ($rose(s_q.done) && s_q.doneIe |-> irq)
        else $error("done interrupt missing");
    chk_bad_key: assert property (cmdWrite && wdata[31:POS_KEY] != CMD_KEY
                                  |=> s_q.progErr ##1 s_q.done)
        else $error("bad key not flagged");
    chk_erase_locked: assert property (cmdWrite && cmdCode == ERASE_ALL_CMD &&
                                       s_q.locks != 4'h0 && wdata[31:POS_KEY] == CMD_KEY
                                       |=> s_q.lockErr)
        else $error("erase all not refused");
    chk_abort_wins: assert property (asrRead && abortEvt |=> s_q.unread)
        else $error("abort lost to read clear");

    cov_abort: cover property (abortEvt);
    cov_seq_fetch: cover property (accStart && isSeq ##[1:4] memAck);
    cov_page_write: cover property (s_q.doExec && s_q.code == WRITE_PAGE_CMD);
    cov_lock_err: cover property ($rose(s_q.lockErr));
endmodule

// file: rtl/flash_ctrl_pkg.sv
// Purpose: Constants for the abort status and flash controller block.
// Assumes: AXI4-Lite register bus, one 20 MHz clock.
// Notes:   Behaviour
package flash_ctrl_pkg;
    localparam logic [7:0]  OFS_ABORT_STATUS  = 8'h04;
    localparam logic [7:0]  OFS_ABORT_ADDRESS = 8'h08;
    localparam logic [7:0]  OFS_FLASH_MODE    = 8'h60;
    localparam logic [7:0]  OFS_FLASH_CMD     = 8'h64;
    localparam logic [7:0]  OFS_FLASH_STATUS  = 8'h68;
    localparam int          POS_UNDEF  = 0;
    localparam int          POS_MISAL  = 1;
    localparam int          POS_SIZE   = 8;
    localparam int          POS_TYPE   = 10;
    localparam int          POS_SRC    = 16;
    localparam int          POS_SAVED  = 24;
    localparam int          POS_DONE   = 0;
    localparam int          POS_LOCK_ERROR_FLAG  = 2;
    localparam int          POS_PROGRAM_ERROR_FLAG  = 3;
    localparam int          POS_SEC    = 4;
    localparam int          POS_GP     = 8;
    localparam int          POS_LOCKS  = 16;
    localparam int          POS_FWS    = 8;
    localparam int          POS_MICROSECOND_CYCLE_COUNT   = 16;
    localparam int          POS_PAGE   = 8;
    localparam int          POS_KEY    = 24;
    localparam logic [7:0]  CMD_KEY    = 8'h5A;
    localparam logic [7:0]  WRITE_PAGE_CMD      = 8'h01;
    localparam logic [7:0]  SET_LOCK_CMD        = 8'h02;
    localparam logic [7:0]  WRITE_PAGE_LOCK_CMD = 8'h03;
    localparam logic [7:0]  CLEAR_LOCK_CMD      = 8'h04;
    localparam logic [7:0]  ERASE_ALL_CMD       = 8'h08;
    localparam logic [7:0]  SET_GP_BIT_CMD      = 8'h0B;
    localparam logic [7:0]  CLEAR_GP_BIT_CMD    = 8'h0D;
    localparam logic [7:0]  SET_SECURITY_CMD    = 8'h0F;
    localparam int          PAGE_WORDS  = 64;
    localparam int          PAGES       = 16;
    localparam int          REGIONS     = 4;
    localparam int          GP_BITS     = 3;
    localparam logic [1:0]  RST_FWS     = 2'h0;
    localparam logic [7:0]  RST_MICROSECOND_CYCLE_COUNT    = 8'h00;
    localparam logic [1:0]  SIZE_BYTE   = 2'h0;
    localparam logic [1:0]  SIZE_HALF   = 2'h1;
    localparam logic [1:0]  SIZE_WORD   = 2'h2;
    localparam logic [1:0]  TYPE_READ   = 2'h0;
    localparam logic [1:0]  TYPE_WRITE  = 2'h1;
    localparam logic [1:0]  TYPE_FETCH  = 2'h2;
    localparam logic [1:0]  RESP_OKAY   = 2'h0;
    localparam logic [1:0]  RESP_SLVERR = 2'h2;
endpackage

// file: sim/mem_master_model.sv
// Purpose: Memory port master for the flash bench.
// Assumes: Ack is sampled on the falling edge, where it has settled.
// Notes:   Released address and data lines show inverted values; size, type and master keep their old ones.
`timescale 1ns/1ps
module mem_master_model (
    // Clock
    input  wire logic        clock,
    // Memory port
    output logic             memReq,
    output logic [31:0]      memAddr,
    output logic [1:0]       memSize,
    output logic [1:0]       memType,
    output logic [2:0]       memMaster,
    output logic [31:0]      memWdata,
    input  wire logic        memAck,
    input  wire logic        memAbort,
    input  wire logic [31:0] memRdata
);
    initial {memReq, memAddr, memSize, memType, memMaster, memWdata} = '0;
    // Callers offer word and halfword writes
    task automatic access(input logic [31:0] a, input logic [6:0] stm, input logic [31:0] d,
                          output logic ab, output logic [31:0] rd, output int w);
        w = -2;
        @(posedge clock);
        {memReq, memAddr, memSize, memType, memMaster, memWdata} <= {1'b1, a, stm, d};
        do begin
            @(negedge clock);
            w++;
        end while (memAck !== 1'b1 && w < 60);
        {ab, rd} = {memAbort, memRdata};
        @(posedge clock);
        {memReq, memAddr, memWdata} <= {1'b0, ~a, ~d};
    endtask
endmodule

// file: sim/testbench.sv
// Purpose: Self-checking bench for the abort status and flash block.
// Assumes: Cycle count of 8 keeps commands short.
// Notes:   Erased flash contents are not checked.
`timescale 1ns/1ps
module testbench import flash_ctrl_pkg::*; ;
    logic clock = 0, rst_n = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [7:0] awaddr = '0, araddr = '0;
    logic [31:0] wdata = '0, rd, rdData, rdata, memAddr, memWdata, memRdata;
    logic [1:0] bresp, rresp, rr, memSize, memType;
    logic [2:0] memMaster;
    logic ab, awready, wready, bvalid, arready, rvalid, memReq, memAck, memAbort, irq;
    int failures = 0, tests_run = 0, w;
    logic [31:0] cv [12] = '{32'hA500_0001, 32'h5A00_0007, 32'h5A00_0002, 32'h5A00_0008,
        32'h5A00_0101, 32'h5A00_0004, 32'h5A00_0008, 32'h5A00_0101, 32'h5A00_000B,
        32'h5A00_000D, 32'h5A00_0103, 32'h5A00_000F};
    logic [19:0] cx [12] = '{20'h9, 20'h9, 20'h10001, 20'h10005, 20'h10005, 20'h1, 20'h1,
        20'h1, 20'h101, 20'h1, 20'h10001, 20'h10011};
    logic [11:0] slow = 12'hFE4;
    initial forever #25 clock = ~clock;
    flash_ctrl_abort_status flash_ctrl_abort_status_inst (.clock(clock), .rst_n(rst_n),
        .ce(1'b1), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata),
        .wstrb(4'hF), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid),
        .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
        .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .memReq(memReq),
        .memAddr(memAddr), .memSize(memSize), .memType(memType), .memMaster(memMaster),
        .memWdata(memWdata), .memAck(memAck), .memAbort(memAbort), .memRdata(memRdata),
        .irq(irq));
    mem_master_model mem_master_model_inst (.clock(clock), .memReq(memReq),
        .memAddr(memAddr), .memSize(memSize), .memType(memType), .memMaster(memMaster),
        .memWdata(memWdata), .memAck(memAck), .memAbort(memAbort), .memRdata(memRdata));
    task automatic check(string n, logic [31:0] s, logic [31:0] e);
        tests_run++;
        if (s !== e) begin
            failures++;
            $display("[FAIL] %s exp %h got %h", n, e, s);
        end
    endtask
    task automatic wr(logic [7:0] a, logic [31:0] d);
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid, bready} <= {a, d, 3'b111};
        do @(negedge clock); while (awready !== 1'b1);
        @(posedge clock);
        {awaddr, wdata, awvalid, wvalid} <= {~a, ~d, 2'b00};
        do @(negedge clock); while (bvalid !== 1'b1);
        check("bresp", {30'h0, bresp}, {30'h0, RESP_OKAY});
        @(posedge clock);
        bready <= 1'b0;
    endtask
    task automatic rdr(logic [7:0] a);
        @(posedge clock);
        {araddr, arvalid, rready} <= {a, 2'b11};
        do @(negedge clock); while (arready !== 1'b1);
        @(posedge clock);
        {araddr, arvalid} <= {~a, 1'b0};
        do @(negedge clock); while (rvalid !== 1'b1);
        {rd, rr} = {rdata, rresp};
        @(posedge clock);
        rready <= 1'b0;
    endtask
    task automatic mem(logic [31:0] a, logic [6:0] stm, logic [31:0] d = '0);
        mem_master_model_inst.access(a, stm, d, ab, rdData, w);
    endtask
    task automatic conclude;
        $display("checks %0d failures %0d", tests_run, failures);
        if (failures == 0 && tests_run > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_abort;
        rdr(OFS_ABORT_STATUS);
        check("statusReset", rd, 32'h0);
        rdr(8'h40);
        check("unmapped", {30'h0, rr}, {30'h0, RESP_SLVERR});
        mem(32'h0040_0000, {SIZE_BYTE, TYPE_READ, 3'h4});
        check("undefAbort", {31'h0, ab}, 32'h1);
        rdr(OFS_ABORT_STATUS);
        check("undefStatus", rd, 32'h0004_0001);
        rdr(OFS_ABORT_ADDRESS);
        check("undefAddr", rd, 32'h0040_0000);
        mem(32'h2, {SIZE_WORD, TYPE_READ, 3'h1});
        mem(32'h102, {SIZE_WORD, TYPE_WRITE, 3'h2});
        rdr(OFS_ABORT_STATUS);
        check("savedStatus", rd, 32'h0102_0602);
        rdr(OFS_ABORT_STATUS);
        check("savedCleared", rd, 32'h0002_0602);
        rdr(OFS_ABORT_ADDRESS);
        check("misalAddr", rd, 32'h102);
        mem(32'hF000_0001, {SIZE_HALF, TYPE_FETCH, 3'h4});
        rdr(OFS_ABORT_STATUS);
        check("fetchStatus", rd, 32'h0004_0901);
        mem(32'h1, {SIZE_HALF, TYPE_WRITE, 3'h4});
        check("misalAbort", {31'h0, ab}, 32'h1);
        // Status read and a new abort taken at the same edge
        fork
            rdr(OFS_ABORT_STATUS);
            mem(32'h3, {SIZE_WORD, TYPE_READ, 3'h1});
        join
        check("readBeforeAbort", rd, 32'h0004_0502);
        rdr(OFS_ABORT_STATUS);
        check("abortKept", rd, 32'h0001_0202);
    endtask
    task automatic t_cmd;
        int k;
        wr(OFS_FLASH_MODE, 32'h0008_0001);
        mem(32'h0010_0104, {SIZE_WORD, TYPE_WRITE, 3'h4}, 32'hCAFE_0001);
        for (int i = 0; i < 12; i++) begin
            wr(OFS_FLASH_CMD, cv[i]);
            k = 0;
            do begin
                rdr(OFS_FLASH_STATUS);
                k++;
                if (k == 1 && rd[0] === 1'b0) check("irqBusy", {31'h0, irq}, 32'h0);
            end while (rd[0] !== 1'b1 && k < 40);
            check("cmdStatus", rd, {12'h0, cx[i]});
            check("cmdBusy", {31'h0, k > 1}, {31'h0, slow[i]});
            check("irqDone", {31'h0, irq}, 32'h1);
            if (i == 7) begin
                mem(32'h104, {SIZE_WORD, TYPE_READ, 3'h4});
                check("flashData", rdData, 32'hCAFE_0001);
                mem(32'h0008_0104, {SIZE_BYTE, TYPE_READ, 3'h4});
                check("aliasData", rdData, 32'hCAFE_0001);
            end
        end
    endtask
    task automatic t_wait;
        for (int f = 0; f < 4; f++) begin
            wr(OFS_FLASH_MODE, 32'h0008_0001 | (f << 8));
            mem(32'h104, {SIZE_WORD, TYPE_READ, 3'h4});
            check("readWait", w, f);
            mem(32'h108, {SIZE_WORD, TYPE_READ, 3'h4});
            check("dataNoBuf", w, f);
            mem(32'h104, {SIZE_WORD, TYPE_FETCH, 3'h4});
            check("fetch1", w, f);
            mem(32'h108, {SIZE_WORD, TYPE_FETCH, 3'h4});
            check("fetch2", w, 0);
            mem(32'h10C, {SIZE_WORD, TYPE_FETCH, 3'h4});
            check("fetch3", w, f == 1 ? 0 : f);
            mem(32'h0, {SIZE_WORD, TYPE_WRITE, 3'h4}, 32'h1);
            check("writeWait", w, f == 3 ? 3 : f + 1);
        end
    endtask
    initial begin
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        t_abort;
        t_cmd;
        t_wait;
        conclude;
    end
    initial begin
        #1000000;
        failures++;
        conclude;
    end
endmodule
